/* File: inc/sld_pkg.sv */
// package for the segment lcd driver: register map, fields, levels, timing tables
package sld_pkg;
	// register byte offsets on the bus
	localparam logic [3:0] SLD_OFF_CONTROL = 4'h0;
	localparam logic [3:0] SLD_OFF_INDEX = 4'h4;
	localparam logic [3:0] SLD_OFF_WINDOW = 4'h8;
	localparam logic [3:0] SLD_OFF_BOOSTER = 4'hc;
	// control field positions
	localparam int SLD_BIAS_SELECT = 7;
	localparam int SLD_DUTY_HI = 6;
	localparam int SLD_DUTY_LO = 5;
	localparam int SLD_DISPLAY_ENABLE = 4;
	localparam int SLD_WAVEFORM_TYPE = 2;
	localparam int SLD_FRAME_HI = 1;
	localparam int SLD_FRAME_LO = 0;
	localparam logic [7:0] SLD_CONTROL_MASK = 8'hf7;
	localparam logic [7:0] SLD_INDEX_MASK = 8'h1f;
	localparam logic [7:0] SLD_WINDOW_MASK = 8'h0f;
	// booster field positions
	localparam int SLD_BOOST_HI = 2;
	localparam int SLD_BOOST_LO = 1;
	localparam logic [7:0] SLD_BOOSTER_MASK = 8'h06;
	// values after reset
	localparam logic [7:0] SLD_CONTROL_RST = 8'h00;
	localparam logic [7:0] SLD_INDEX_RST = 8'h00;
	localparam logic [7:0] SLD_BOOSTER_RST = 8'h00;
	localparam logic [3:0] SLD_DOTS_RST = 4'h0;
	// drive level codes: ground, first, second, full step
	localparam logic [1:0] SLD_LVL_GND = 2'h0;
	localparam logic [1:0] SLD_LVL_V1 = 2'h1;
	localparam logic [1:0] SLD_LVL_V2 = 2'h2;
	localparam logic [1:0] SLD_LVL_V3 = 2'h3;
	// booster divider terminal counts (divide minus one)
	localparam logic [3:0] SLD_BOOST_DIV1 = 4'h0;
	localparam logic [3:0] SLD_BOOST_DIV4 = 4'h3;
	localparam logic [3:0] SLD_BOOST_DIV8 = 4'h7;
	localparam logic [3:0] SLD_BOOST_DIV16 = 4'hf;

	typedef enum logic [1:0] {SLD_DUTY_HALF, SLD_DUTY_THIRD, SLD_DUTY_QUARTER} sld_duty_t;

	// bus address phase captured for the data phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [3:0] offset;
	} sld_addr_phase_t;

	// sub-oscillator cycles per common slot, by duty and frame code
	function automatic logic [8:0] sld_slot_count(input sld_duty_t duty, input logic [1:0] rate);
		logic [8:0] cnt;
		cnt = 9'h100;
		case (duty)
			SLD_DUTY_HALF: cnt = (rate == 2'h0) ? 9'h100 : (rate == 2'h1) ? 9'h118 :
				(rate == 2'h2) ? 9'h130 : 9'h0e8;
			SLD_DUTY_THIRD: cnt = (rate == 2'h0) ? 9'h0ac : (rate == 2'h1) ? 9'h0bc :
				(rate == 2'h2) ? 9'h0cc : 9'h09c;
			default: cnt = (rate == 2'h0) ? 9'h080 : (rate == 2'h1) ? 9'h08c :
				(rate == 2'h2) ? 9'h098 : 9'h074;
		endcase
		return cnt;
	endfunction : sld_slot_count
endpackage : sld_pkg

/* File: rtl/sld_segment_lcd_driver.sv */
// segment lcd driver: bus registers, display ram and multiplexed drive levels
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1 - thirty-two segment lines and four common lines drive a four by thirty-two dot array
// R2 - all frame timing advances only on sub-oscillator cycles
// R3 - driver keeps running in every cpu power mode; no mode input stops it
// R4 - control bit 7 picks half bias at zero, third bias at one
// R5 - control bits 6..5 pick half, third or quarter duty
// R6 - control bit 4 turns the display on or off
// R7 - while off, every common and segment sits at ground
// R8 - control bit 2 picks the A or B drive waveform
// R9 - control bits 1..0 pick the per-common cycle count by duty
// R10 - index register holds a five-bit ram index naming segment 0 to 31
// R11 - index bits 7..5 always read zero
// R12 - window register moves four dots, bit n for common n
// R13 - booster bits 2..1 pick sub-oscillator divided by 1, 4, 8 or 16
// R14 - software writes the index first, then reads or writes the window
// R15 - commons are scanned in turn; segments take on or off levels from ram
module sld_segment_lcd_driver #(
	parameter int NUM_SEG = 32,
	parameter int NUM_COM = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// sub-oscillator cycle enable
	input wire logic subClkEn,
	// panel drive levels and booster clock enable
	output logic [2*NUM_COM-1:0] commonLine,
	output logic [2*NUM_SEG-1:0] segmentLine,
	output logic boosterTick
);
	import sld_pkg::*;

	logic [7:0] displayControl_r;
	logic [7:0] ramIndex_r;
	logic [7:0] boosterControl_r;
	logic [3:0] dotRam_r [NUM_SEG];
	sld_addr_phase_t addrPhase_r;
	logic readPending_r;
	logic [3:0] readOffset_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic [8:0] slotCnt_r;
	logic [1:0] comIdx_r;
	logic polarity_r;
	logic [3:0] boostCnt_r;
	logic boosterTick_r;
	logic [2*NUM_COM-1:0] commonLine_r;
	logic [2*NUM_SEG-1:0] segmentLine_r;

	// decoded control fields
	logic biasThird;
	logic enabled;
	logic typeB;
	logic [1:0] frameRate;
	sld_duty_t duty;
	logic [1:0] lastCom;
	logic [8:0] slotLen;
	logic [3:0] boostDiv;
	logic addrTaken;
	logic dataWrite;
	logic wrControl;
	logic wrIndex;
	logic wrWindow;
	logic wrBooster;
	logic slotEnd;
	logic halfPoint;
	logic frameEnd;
	logic boostWrap;
	logic [7:0] readValue;

	assign biasThird = displayControl_r[SLD_BIAS_SELECT]; // [R4]
	assign enabled = displayControl_r[SLD_DISPLAY_ENABLE]; // [R6]
	assign typeB = displayControl_r[SLD_WAVEFORM_TYPE]; // [R8]
	assign frameRate = {displayControl_r[SLD_FRAME_HI], displayControl_r[SLD_FRAME_LO]};

	always_comb begin
		if (displayControl_r[SLD_DUTY_HI]) begin // [R5]
			duty = SLD_DUTY_QUARTER;
			lastCom = 2'h3;
		end else if (displayControl_r[SLD_DUTY_LO]) begin
			duty = SLD_DUTY_THIRD;
			lastCom = 2'h2;
		end else begin
			duty = SLD_DUTY_HALF;
			lastCom = 2'h1;
		end
	end

	assign slotLen = sld_slot_count(duty, frameRate); // [R9]

	// slot, half-slot and frame boundaries of the scan
	assign slotEnd = slotCnt_r >= slotLen - 9'h1; // [R9]
	assign halfPoint = slotCnt_r == (slotLen >> 1) - 9'h1;
	assign frameEnd = comIdx_r >= lastCom; // [R5]
	assign boostWrap = boostCnt_r >= boostDiv; // [R13]

	always_comb begin
		case ({boosterControl_r[SLD_BOOST_HI], boosterControl_r[SLD_BOOST_LO]}) // [R13]
			2'h0: boostDiv = SLD_BOOST_DIV1;
			2'h1: boostDiv = SLD_BOOST_DIV4;
			2'h2: boostDiv = SLD_BOOST_DIV8;
			default: boostDiv = SLD_BOOST_DIV16;
		endcase
	end

	// offset match for a register access
	function automatic logic reg_hit(input logic [3:0] offset, input logic [3:0] target);
		return offset == target;
	endfunction : reg_hit

	// bus: address phase capture, zero-wait writes, one-wait reads
	assign addrTaken = hsel && htrans[1] && hready;

	// write strobes decoded in the data phase
	assign dataWrite = addrPhase_r.valid && addrPhase_r.write;
	assign wrControl = dataWrite && reg_hit(addrPhase_r.offset, SLD_OFF_CONTROL);
	assign wrIndex = dataWrite && reg_hit(addrPhase_r.offset, SLD_OFF_INDEX);
	assign wrWindow = dataWrite && reg_hit(addrPhase_r.offset, SLD_OFF_WINDOW);
	assign wrBooster = dataWrite && reg_hit(addrPhase_r.offset, SLD_OFF_BOOSTER);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addrPhase_r <= '0;
		end else if (hready) begin
			addrPhase_r.valid <= addrTaken;
			addrPhase_r.write <= hwrite;
			addrPhase_r.offset <= haddr[3:0];
		end
	end

	// a read waits one cycle so a write just before it has landed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			readPending_r <= 1'b0;
			readOffset_r <= 4'h0;
			hreadyout_r <= 1'b1;
		end else if (readPending_r) begin
			readPending_r <= 1'b0;
			hreadyout_r <= 1'b1;
		end else if (addrTaken && !hwrite) begin
			readPending_r <= 1'b1;
			readOffset_r <= haddr[3:0];
			hreadyout_r <= 1'b0;
		end
	end

	// read data chosen from the latched offset
	always_comb begin
		case (readOffset_r)
			SLD_OFF_CONTROL: readValue = displayControl_r & SLD_CONTROL_MASK;
			SLD_OFF_INDEX: readValue = ramIndex_r & SLD_INDEX_MASK; // [R11]
			SLD_OFF_WINDOW: readValue = {4'h0, dotRam_r[ramIndex_r[4:0]]}; // [R12] [R14]
			SLD_OFF_BOOSTER: readValue = boosterControl_r & SLD_BOOSTER_MASK;
			default: readValue = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hrdata_r <= 32'h0;
		end else if (readPending_r) begin
			hrdata_r <= {24'h0, readValue};
		end
	end

	// register writes in the data phase
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			displayControl_r <= SLD_CONTROL_RST;
			ramIndex_r <= SLD_INDEX_RST;
			boosterControl_r <= SLD_BOOSTER_RST;
		end else begin
			if (wrControl) begin
				displayControl_r <= hwdata[7:0] & SLD_CONTROL_MASK;
			end
			if (wrIndex) begin
				ramIndex_r <= hwdata[7:0] & SLD_INDEX_MASK; // [R10] [R11]
			end
			if (wrBooster) begin
				boosterControl_r <= hwdata[7:0] & SLD_BOOSTER_MASK;
			end
		end
	end

	// display ram: one four-dot entry per segment
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_SEG; i++) begin
				dotRam_r[i] <= SLD_DOTS_RST;
			end
		end else if (wrWindow) begin
			dotRam_r[ramIndex_r[4:0]] <= hwdata[3:0]; // [R12] [R14]
		end
	end

	// frame timing on sub-oscillator cycles; runs in any cpu power mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !enabled) begin
			slotCnt_r <= 9'h0;
			comIdx_r <= 2'h0;
			polarity_r <= 1'b0;
		end else if (subClkEn) begin // [R2] [R3]
			if (slotEnd) begin
				slotCnt_r <= 9'h0;
				if (frameEnd) begin // [R15]
					comIdx_r <= 2'h0;
					if (typeB) begin
						polarity_r <= ~polarity_r; // [R8]
					end
				end else begin
					comIdx_r <= comIdx_r + 2'h1;
				end
				if (!typeB) begin
					polarity_r <= 1'b0;
				end
			end else begin
				slotCnt_r <= slotCnt_r + 9'h1;
				if (!typeB && halfPoint) begin
					polarity_r <= 1'b1; // [R8]
				end
			end
		end
	end

	// booster clock enable divided from the sub-oscillator
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			boostCnt_r <= 4'h0;
			boosterTick_r <= 1'b0;
		end else if (subClkEn) begin
			if (boostWrap) begin // [R13]
				boostCnt_r <= 4'h0;
				boosterTick_r <= 1'b1;
			end else begin
				boostCnt_r <= boostCnt_r + 4'h1;
				boosterTick_r <= 1'b0;
			end
		end else begin
			boosterTick_r <= 1'b0;
		end
	end

	// drive levels: selected common swings fully, segments oppose it when on
	function automatic logic [1:0] idle_level(input logic pol, input logic third);
		if (!third) begin
			return SLD_LVL_V1;
		end
		return pol ? SLD_LVL_V2 : SLD_LVL_V1;
	endfunction : idle_level

	// full swing: top level when high, ground when low
	function automatic logic [1:0] full_level(input logic high);
		return high ? SLD_LVL_V3 : SLD_LVL_GND;
	endfunction : full_level

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !enabled) begin
			commonLine_r <= '0; // [R7]
		end else begin
			for (int c = 0; c < NUM_COM; c++) begin // [R1]
				if (c[1:0] == comIdx_r) begin
					commonLine_r[2*c +: 2] <= full_level(~polarity_r); // [R15]
				end else begin
					commonLine_r[2*c +: 2] <= idle_level(polarity_r, biasThird); // [R4]
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !enabled) begin
			segmentLine_r <= '0; // [R7]
		end else begin
			for (int s = 0; s < NUM_SEG; s++) begin // [R1]
				if (dotRam_r[s][comIdx_r]) begin
					segmentLine_r[2*s +: 2] <= full_level(polarity_r); // [R15]
				end else begin
					segmentLine_r[2*s +: 2] <= idle_level(~polarity_r, biasThird); // [R4]
				end
			end
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign commonLine = commonLine_r;
	assign segmentLine = segmentLine_r;
	assign boosterTick = boosterTick_r;
endmodule : sld_segment_lcd_driver

`default_nettype wire

/* File: tb/sld_lcd_monitor.sv */
// port checker for the segment lcd driver, bound to the design top
`timescale 1ns/10ps
`default_nettype none
module sld_lcd_monitor
	import sld_pkg::*;
#(
	parameter int NUM_SEG = 32,
	parameter int NUM_COM = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	// panel side
	input wire logic subClkEn,
	input wire logic [2*NUM_COM-1:0] commonLine,
	input wire logic [2*NUM_SEG-1:0] segmentLine,
	input wire logic boosterTick
);
	sld_addr_phase_t apR;
	logic [7:0] ctrlR;
	logic [1:0] boostR;
	logic [NUM_COM-1:0] comSel;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) apR <= '0;
		else if (hready) apR <= '{hsel && htrans[1], hwrite, haddr[3:0]};
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ctrlR <= SLD_CONTROL_RST;
		else if (hready && apR.valid && apR.write && apR.offset == SLD_OFF_CONTROL) ctrlR <= hwdata[7:0];
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) boostR <= 2'h0;
		else if (hready && apR.valid && apR.write && apR.offset == SLD_OFF_BOOSTER) boostR <= hwdata[2:1];
	end
	// a common is selected when both level bits agree
	always_comb begin
		for (int n = 0; n < NUM_COM; n++) comSel[n] = commonLine[2*n+1] ~^ commonLine[2*n];
	end
	chk_off_ground: assert property (!ctrlR[4] && !$past(ctrlR[4]) |-> commonLine == '0 && segmentLine == '0)
		else $error("lines not at ground while display off");
	chk_read_wait: assert property (hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_index_upper: assert property (apR.valid && !apR.write && apR.offset == SLD_OFF_INDEX && hreadyout |-> hrdata[31:5] == '0)
		else $error("index upper bits not zero");
	chk_window_upper: assert property (apR.valid && !apR.write && apR.offset == SLD_OFF_WINDOW && hreadyout |-> hrdata[31:4] == '0)
		else $error("window upper bits not zero");
	chk_boost_every: assert property (boostR == 2'h0 && $past(boostR) == 2'h0 && subClkEn |=> boosterTick)
		else $error("booster tick missing at full rate");
	chk_tick_cause: assert property (boosterTick |-> $past(subClkEn))
		else $error("booster tick without sub cycle");
	chk_common_hold: assert property (!$past(subClkEn) && !$past(subClkEn, 2) && $past(ctrlR) == ctrlR && $past(ctrlR, 2) == ctrlR |-> $stable(commonLine))
		else $error("common moved without sub cycle");
	chk_one_selected: assert property (ctrlR[4] && ctrlR[6] && $past(ctrlR) == ctrlR && $past(ctrlR, 2) == ctrlR |-> $onehot(comSel))
		else $error("not exactly one common selected");
endmodule : sld_lcd_monitor

bind sld_segment_lcd_driver sld_lcd_monitor #(.NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM)) u_mon (.ref_clk, .rst_n,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .subClkEn, .commonLine,
	.segmentLine, .boosterTick);
`default_nettype wire

/* File: tb/sld_panel_model.sv */
// panel glass model: a dot lights at opposite full levels
`timescale 1ns/10ps
`default_nettype none
module sld_panel_model (
	// drive levels
	input wire logic [7:0] commonLine,
	input wire logic [63:0] segmentLine,
	// segments lit on any common
	output logic [31:0] litSeg
);
	always_comb begin
		litSeg = '0;
		for (int s = 0; s < 32; s++) begin
			for (int c = 0; c < 4; c++) begin
				if ({commonLine[2*c+:2], segmentLine[2*s+:2]} inside {4'hc, 4'h3}) litSeg[s] = 1'b1;
			end
		end
	end
endmodule : sld_panel_model
`default_nettype wire

/* File: tb/sld_segment_lcd_driver_test.sv */
// self-checking bench for the segment lcd driver
`timescale 1ns/10ps
`default_nettype none
module sld_segment_lcd_driver_test;
	import sld_pkg::*;
	logic ref_clk = 0, rst_n = 0, hwrite = 0, subClkEn = 0, subAll = 0, rdPend = 0, lnPend = 0, pol;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, litSeg, el;
	logic hreadyout, hresp, boosterTick;
	logic [7:0] commonLine, ec;
	logic [63:0] segmentLine;
	logic [3:0] dots [32];
	logic [7:0] mode [5] = '{8'hf3, 8'hf7, 8'h70, 8'h91, 8'hb2};
	int half [5] = '{58, 58, 64, 140, 102};
	int nk [5] = '{8, 8, 8, 4, 6};
	logic [31:0] rdQ [$];
	logic [39:0] lnQ [$];
	int seed = 32'h44092c96, n_errors = 0, checks_done = 0;
	always #4 ref_clk = ~ref_clk;
	sld_segment_lcd_driver dut (.ref_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .subClkEn, .commonLine,
		.segmentLine, .boosterTick);
	sld_panel_model panel (.commonLine, .segmentLine, .litSeg);
	always @(posedge ref_clk) subClkEn <= subAll | 1'($random(seed));
	task automatic cmpRd(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t read %h expected %h", $time, got, exp);
		end
	endtask : cmpRd
	task automatic cmpLn(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t lines %h expected %h", $time, got, exp);
		end
	endtask : cmpLn
	always @(posedge ref_clk) begin
		if (rdPend && hreadyout) cmpRd(hrdata, rdQ.pop_front());
		if (rdPend && hreadyout) cmpRd({31'h0, hresp}, 32'h0);
		if (lnPend) cmpLn({commonLine, litSeg}, lnQ.pop_front());
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		haddr <= {28'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge ref_clk); while (!hreadyout);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		rdQ.push_back(exp);
		haddr <= {28'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (!hreadyout);
		htrans <= 2'h0;
		rdPend <= 1'b1;
		do @(posedge ref_clk); while (!hreadyout);
		rdPend <= 1'b0;
	endtask : rd
	task automatic ln(input logic [39:0] exp);
		lnQ.push_back(exp);
		lnPend <= 1'b1;
		@(posedge ref_clk);
		lnPend <= 1'b0;
	endtask : ln
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		#(20000 * 8);
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) rd(4'(4 * i), 32'h0);
		wr(SLD_OFF_INDEX, 8'hff);
		rd(SLD_OFF_INDEX, 32'h1f);
		wr(SLD_OFF_CONTROL, 8'hef);
		rd(SLD_OFF_CONTROL, 32'he7);
		for (int s = 0; s < 32; s++) begin
			dots[s] = 4'($random(seed));
			wr(SLD_OFF_INDEX, 8'(s));
			wr(SLD_OFF_WINDOW, {4'hf, dots[s]});
			rd(SLD_OFF_WINDOW, {28'h0, dots[s]});
		end
		subAll <= 1'b1;
		for (int t = 0; t < 5; t++) begin
			wr(SLD_OFF_CONTROL, 8'h00);
			@(posedge ref_clk);
			ln(40'h0);
			wr(SLD_OFF_CONTROL, mode[t]);
			repeat (10) @(posedge ref_clk);
			for (int k = 0; k < nk[t]; k++) begin
				pol = mode[t][2] ? 1'b0 : k[0];
				for (int n = 0; n < 4; n++) ec[2*n+:2] = n == k / 2 ? {2{!pol}} : pol && mode[t][7] ? 2'h2 : 2'h1;
				for (int s = 0; s < 32; s++) el[s] = dots[s][k/2];
				ln({ec, el});
				repeat (half[t] - 1) @(posedge ref_clk);
			end
		end
		wr(SLD_OFF_BOOSTER, 8'hff);
		rd(SLD_OFF_BOOSTER, 32'h6);
		finish_test;
	end
endmodule : sld_segment_lcd_driver_test
`default_nettype wire
